// file: rtl/label_access_resolve.sv
`timescale 1ns/1ps
`default_nettype none
`include "label_ctrl_consts.svh"

module label_access_resolve #(
  parameter bit HAVE_L3 = 1'b0
) (
  // Access under decision
  input wire label_ctrl_pkg::access_t acc,
  input wire label_ctrl_pkg::context_t ctx,
  input wire logic l1_label_trap,
  // Decision
  output label_ctrl_pkg::outcome_t outcome
);

  logic to_l3;
  logic l3_outcome_undef;
  logic nv_all;

  assign to_l3 = HAVE_L3 && ctx.lower_level_trap;
  // A trap to level 3 while halted with secure debug off becomes undefined
  assign l3_outcome_undef = ctx.halted && ctx.secure_debug_disabled;
  assign nv_all = ({ctx.nv2, ctx.nv1, ctx.nv} == `LBL_NV_REDIRECT);

  always_comb begin
    outcome = label_ctrl_pkg::OUT_UNDEF;
    case (acc.level)
      label_ctrl_pkg::LVL_0: begin
        outcome = label_ctrl_pkg::OUT_UNDEF;
      end
      label_ctrl_pkg::LVL_1: begin
        if (!acc.names_l1) begin
          if (ctx.el2_enabled && ctx.nv) begin
            if (to_l3) begin
              outcome = l3_outcome_undef ? label_ctrl_pkg::OUT_UNDEF
                                         : label_ctrl_pkg::OUT_TRAP_L3;
            end else begin
              outcome = label_ctrl_pkg::OUT_TRAP_L2;
            end
          end else begin
            outcome = label_ctrl_pkg::OUT_UNDEF;
          end
        end else if (to_l3) begin
          outcome = l3_outcome_undef ? label_ctrl_pkg::OUT_UNDEF
                                     : label_ctrl_pkg::OUT_TRAP_L3;
        end else if (ctx.el2_enabled && l1_label_trap) begin
          outcome = label_ctrl_pkg::OUT_TRAP_L2;
        end else if (ctx.el2_enabled && nv_all) begin
          outcome = label_ctrl_pkg::OUT_MEM;
        end else begin
          outcome = label_ctrl_pkg::OUT_DONE_L1;
        end
      end
      label_ctrl_pkg::LVL_2: begin
        if (to_l3) begin
          outcome = l3_outcome_undef ? label_ctrl_pkg::OUT_UNDEF
                                     : label_ctrl_pkg::OUT_TRAP_L3;
        end else if (!acc.names_l1 || ctx.host_extension_mode) begin
          outcome = label_ctrl_pkg::OUT_DONE_L2;
        end else begin
          outcome = label_ctrl_pkg::OUT_DONE_L1;
        end
      end
      default: begin
        outcome = acc.names_l1 ? label_ctrl_pkg::OUT_DONE_L1
                               : label_ctrl_pkg::OUT_DONE_L2;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/label_ctrl_consts.svh
`ifndef LABEL_CTRL_CONSTS_SVH
`define LABEL_CTRL_CONSTS_SVH

// Field positions of the level-2 label register
`define LBL_ENABLE_BIT 63
`define LBL_ID_TRAP_BIT 58
`define LBL_LOWER_ALT_BIT 56
`define LBL_OWN_ALT_BIT 55
`define LBL_ALT_FORCED_BIT 54
`define LBL_SM_TRAP_BIT 50
`define LBL_L0_TRAP_BIT 49
`define LBL_L1_TRAP_BIT 48
`define LBL_DPMG_HI 47
`define LBL_DPMG_LO 40
`define LBL_IPMG_HI 39
`define LBL_IPMG_LO 32
`define LBL_DPID_HI 31
`define LBL_DPID_LO 16
`define LBL_IPID_HI 15
`define LBL_IPID_LO 0

// Reset values
`define LBL_ENABLE_RST 1'h0
`define LBL_TRAP_RST_NO_L3 1'h1
`define LBL_TRAP_RST_L3 1'h0
`define LBL_FIELD_RST 1'h0
`define LBL_PMG_RST 8'h00
`define LBL_PID_RST 16'h0000

// Exception class reported for a trapped access
`define LBL_TRAP_CLASS 6'h18
// Offset into the virtual register page for redirected level-1 accesses
`define LBL_NV_MEM_OFFSET 12'h900
// Nested virtualization bits that redirect to memory
`define LBL_NV_REDIRECT 3'h7

`endif

// file: rtl/label_ctrl_pkg.sv
`default_nettype none
package label_ctrl_pkg;

  typedef enum logic [1:0] {
    LVL_0 = 2'b00,
    LVL_1 = 2'b01,
    LVL_2 = 2'b10,
    LVL_3 = 2'b11
  } level_t;

  typedef enum logic [2:0] {
    OUT_DONE_L2 = 3'b000,
    OUT_DONE_L1 = 3'b001,
    OUT_MEM     = 3'b010,
    OUT_TRAP_L2 = 3'b011,
    OUT_TRAP_L3 = 3'b100,
    OUT_UNDEF   = 3'b101
  } outcome_t;

  typedef struct packed {
    level_t level;
    logic is_write;
    logic names_l1;
    logic [63:0] wdata;
  } access_t;

  typedef struct packed {
    logic el2_enabled;
    logic nv;
    logic nv1;
    logic nv2;
    logic host_extension_mode;
    logic halted;
    logic secure_debug_disabled;
    logic lower_level_trap;
  } context_t;

  typedef struct packed {
    logic active;
    logic [15:0] data_partition_id;
    logic [15:0] instr_partition_id;
    logic [7:0] data_monitor_group;
    logic [7:0] instr_monitor_group;
    logic own_alt_space;
    logic lower_alt_space;
  } labels_t;

endpackage
`default_nettype wire

// file: rtl/partition_label_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "label_ctrl_consts.svh"

module partition_label_control #(
  parameter bit HAVE_L3 = 1'b0,
  parameter bit HAS_ID_TRAP = 1'b1,
  parameter bit HAS_ALT_SPACE = 1'b1,
  parameter bit HAS_STREAMING = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // System register access
  input wire logic acc_valid,
  input wire label_ctrl_pkg::access_t acc,
  input wire label_ctrl_pkg::context_t ctx,
  // Level-3 and hypervisor state
  input wire logic l3_label_enable,
  input wire logic hierarchical_alt_space_enable,
  input wire logic higher_alt_force,
  input wire logic hyp_id_access_trap,
  // Shared enable written through the level-1 register
  input wire logic l1_enable_we,
  input wire logic l1_enable_wdata,
  // Access answer
  output logic resp_valid,
  output label_ctrl_pkg::outcome_t resp_outcome,
  output logic [5:0] resp_class,
  output logic [63:0] resp_rdata,
  output logic [11:0] resp_mem_offset,
  // Labels for level-2 requests
  output label_ctrl_pkg::labels_t labels,
  output logic label_enable,
  // Trap controls toward lower levels
  output logic id_access_trap,
  output logic streaming_label_trap,
  output logic level0_label_trap,
  output logic level1_label_trap
);

  // ************************************************************
  // Register fields
  // ************************************************************
  localparam logic TRAP_RST = HAVE_L3 ? `LBL_TRAP_RST_L3 : `LBL_TRAP_RST_NO_L3;

  logic enable_reg;
  logic id_trap_reg;
  logic lower_alt_reg;
  logic own_alt_reg;
  logic sm_trap_reg;
  logic l0_trap_reg;
  logic l1_trap_reg;
  logic [7:0] dpmg_reg;
  logic [7:0] ipmg_reg;
  logic [15:0] dpid_reg;
  logic [15:0] ipid_reg;

  label_ctrl_pkg::outcome_t outcome;
  logic wr_own;
  logic enable_eff;
  logic forced_flag;
  logic [63:0] read_value;

  label_access_resolve #(
    .HAVE_L3(HAVE_L3)
  ) u_resolve (
    .acc(acc),
    .ctx(ctx),
    .l1_label_trap(l1_trap_reg),
    .outcome(outcome)
  );

  assign wr_own = acc_valid && acc.is_write && (outcome == label_ctrl_pkg::OUT_DONE_L2);

  // With level 3 present the enable is that register's live bit
  assign enable_eff = HAVE_L3 ? l3_label_enable : enable_reg;
  assign forced_flag = HAS_ALT_SPACE && (higher_alt_force || own_alt_reg);

  // ************************************************************
  // Shared enable bit
  // ************************************************************
  // Own writes win over a same-cycle write through the level-1 name
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= `LBL_ENABLE_RST;
    end else if (!HAVE_L3) begin
      if (wr_own) begin
        enable_reg <= acc.wdata[`LBL_ENABLE_BIT];
      end else if (l1_enable_we) begin
        enable_reg <= l1_enable_wdata;
      end
    end
  end

  // ************************************************************
  // Control fields
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_trap_reg <= `LBL_FIELD_RST;
      lower_alt_reg <= `LBL_FIELD_RST;
      own_alt_reg <= `LBL_FIELD_RST;
      sm_trap_reg <= `LBL_FIELD_RST;
      l0_trap_reg <= TRAP_RST;
      l1_trap_reg <= TRAP_RST;
    end else if (wr_own) begin
      // Absent optional fields stay zero
      id_trap_reg <= HAS_ID_TRAP && acc.wdata[`LBL_ID_TRAP_BIT];
      lower_alt_reg <= HAS_ALT_SPACE && acc.wdata[`LBL_LOWER_ALT_BIT];
      own_alt_reg <= HAS_ALT_SPACE && acc.wdata[`LBL_OWN_ALT_BIT];
      sm_trap_reg <= HAS_STREAMING && acc.wdata[`LBL_SM_TRAP_BIT];
      l0_trap_reg <= acc.wdata[`LBL_L0_TRAP_BIT];
      l1_trap_reg <= acc.wdata[`LBL_L1_TRAP_BIT];
    end
  end

  // ************************************************************
  // Label fields
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dpmg_reg <= `LBL_PMG_RST;
      ipmg_reg <= `LBL_PMG_RST;
      dpid_reg <= `LBL_PID_RST;
      ipid_reg <= `LBL_PID_RST;
    end else if (wr_own) begin
      dpmg_reg <= acc.wdata[`LBL_DPMG_HI:`LBL_DPMG_LO];
      ipmg_reg <= acc.wdata[`LBL_IPMG_HI:`LBL_IPMG_LO];
      dpid_reg <= acc.wdata[`LBL_DPID_HI:`LBL_DPID_LO];
      ipid_reg <= acc.wdata[`LBL_IPID_HI:`LBL_IPID_LO];
    end
  end

  // ************************************************************
  // Read value and access answer
  // ************************************************************
  always_comb begin
    read_value = 64'h0;
    read_value[`LBL_ENABLE_BIT] = enable_eff;
    read_value[`LBL_ID_TRAP_BIT] = id_trap_reg;
    read_value[`LBL_LOWER_ALT_BIT] = lower_alt_reg;
    read_value[`LBL_OWN_ALT_BIT] = own_alt_reg;
    read_value[`LBL_ALT_FORCED_BIT] = forced_flag;
    read_value[`LBL_SM_TRAP_BIT] = sm_trap_reg;
    read_value[`LBL_L0_TRAP_BIT] = l0_trap_reg;
    read_value[`LBL_L1_TRAP_BIT] = l1_trap_reg;
    read_value[`LBL_DPMG_HI:`LBL_DPMG_LO] = dpmg_reg;
    read_value[`LBL_IPMG_HI:`LBL_IPMG_LO] = ipmg_reg;
    read_value[`LBL_DPID_HI:`LBL_DPID_LO] = dpid_reg;
    read_value[`LBL_IPID_HI:`LBL_IPID_LO] = ipid_reg;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_outcome <= label_ctrl_pkg::OUT_UNDEF;
      resp_class <= 6'h00;
      resp_rdata <= 64'h0;
      resp_mem_offset <= 12'h000;
    end else begin
      resp_valid <= acc_valid;
      if (acc_valid) begin
        resp_outcome <= outcome;
        if (outcome == label_ctrl_pkg::OUT_TRAP_L2 || outcome == label_ctrl_pkg::OUT_TRAP_L3) begin
          resp_class <= `LBL_TRAP_CLASS;
        end else begin
          resp_class <= 6'h00;
        end
        if (!acc.is_write && outcome == label_ctrl_pkg::OUT_DONE_L2) begin
          resp_rdata <= read_value;
        end else begin
          resp_rdata <= 64'h0;
        end
        if (outcome == label_ctrl_pkg::OUT_MEM) begin
          resp_mem_offset <= `LBL_NV_MEM_OFFSET;
        end else begin
          resp_mem_offset <= 12'h000;
        end
      end
    end
  end

  // ************************************************************
  // Label outputs
  // ************************************************************
  // Labels are registered from the fields every cycle, so they follow
  // a write one clock after the fields take it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      labels <= '0;
      label_enable <= 1'b0;
    end else begin
      label_enable <= enable_eff;
      labels.active <= ctx.el2_enabled;
      if (enable_eff && ctx.el2_enabled) begin
        labels.data_partition_id <= dpid_reg;
        labels.instr_partition_id <= ipid_reg;
        labels.data_monitor_group <= dpmg_reg;
        labels.instr_monitor_group <= ipmg_reg;
        labels.own_alt_space <= hierarchical_alt_space_enable && own_alt_reg;
        labels.lower_alt_space <= hierarchical_alt_space_enable && lower_alt_reg;
      end else begin
        labels.data_partition_id <= 16'h0000;
        labels.instr_partition_id <= 16'h0000;
        labels.data_monitor_group <= 8'h00;
        labels.instr_monitor_group <= 8'h00;
        labels.own_alt_space <= 1'b0;
        labels.lower_alt_space <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Trap controls
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_access_trap <= 1'b0;
      streaming_label_trap <= 1'b0;
      level0_label_trap <= 1'b0;
      level1_label_trap <= 1'b0;
    end else begin
      id_access_trap <= ctx.el2_enabled && (id_trap_reg || hyp_id_access_trap);
      streaming_label_trap <= ctx.el2_enabled && sm_trap_reg;
      level0_label_trap <= ctx.el2_enabled && l0_trap_reg;
      level1_label_trap <= ctx.el2_enabled && l1_trap_reg;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_level0_undef: assert property (acc_valid && acc.level == label_ctrl_pkg::LVL_0
    |=> resp_valid && resp_outcome == label_ctrl_pkg::OUT_UNDEF)
    else $error("level-0 access not undefined");

  a_l2_trap_up: assert property (acc_valid && acc.level == label_ctrl_pkg::LVL_2
    && !acc.names_l1 && HAVE_L3 && ctx.lower_level_trap
    && !(ctx.halted && ctx.secure_debug_disabled)
    |=> resp_outcome == label_ctrl_pkg::OUT_TRAP_L3 && resp_class == 6'h18)
    else $error("level-2 access did not trap to level 3");

  a_debug_undef: assert property (acc_valid && acc.level != label_ctrl_pkg::LVL_3
    && HAVE_L3 && ctx.lower_level_trap && ctx.halted && ctx.secure_debug_disabled
    |=> resp_outcome == label_ctrl_pkg::OUT_UNDEF)
    else $error("halted trap not undefined");

  a_nv_redirect: assert property (acc_valid && acc.level == label_ctrl_pkg::LVL_1
    && acc.names_l1 && ctx.el2_enabled && ctx.nv && ctx.nv1 && ctx.nv2
    && !(HAVE_L3 && ctx.lower_level_trap) && !l1_trap_reg
    |=> resp_outcome == label_ctrl_pkg::OUT_MEM && resp_mem_offset == 12'h900)
    else $error("nested access not redirected");

  a_host_retarget: assert property (acc_valid && acc.level == label_ctrl_pkg::LVL_2
    && acc.names_l1 && ctx.host_extension_mode && !(HAVE_L3 && ctx.lower_level_trap)
    |=> resp_outcome == label_ctrl_pkg::OUT_DONE_L2)
    else $error("host-extension access not retargeted");

  a_l1_trap: assert property (acc_valid && acc.level == label_ctrl_pkg::LVL_1
    && acc.names_l1 && ctx.el2_enabled && l1_trap_reg && !(HAVE_L3 && ctx.lower_level_trap)
    |=> resp_outcome == label_ctrl_pkg::OUT_TRAP_L2 && resp_class == 6'h18)
    else $error("level-1 label access not trapped");

  a_enable_gate: assert property (!label_enable
    |-> labels.data_partition_id == 16'h0 && labels.data_monitor_group == 8'h0)
    else $error("labels not default while disabled");

  a_disabled_gate: assert property (!ctx.el2_enabled
    |=> !labels.active && labels.instr_partition_id == 16'h0)
    else $error("labels applied with level 2 disabled");

  a_id_trap_or: assert property (ctx.el2_enabled && hyp_id_access_trap
    |=> id_access_trap)
    else $error("hypervisor id trap ignored");

  a_forced_read: assert property (resp_valid
    && resp_outcome == label_ctrl_pkg::OUT_DONE_L2 && resp_rdata[55] |-> resp_rdata[54])
    else $error("forced flag clear with own alt select set");

  a_write_visible: assert property (wr_own && !HAVE_L3 && acc.wdata[63]
    && ctx.el2_enabled ##1 ctx.el2_enabled
    |=> labels.data_partition_id == $past(acc.wdata[31:16], 2))
    else $error("write not reflected in labels");

  c_mem_redirect: cover property (resp_valid && resp_outcome == label_ctrl_pkg::OUT_MEM);
  c_trap_l3: cover property (resp_valid && resp_outcome == label_ctrl_pkg::OUT_TRAP_L3);
  c_own_write: cover property (wr_own ##2 label_enable);
  c_read_back: cover property (resp_valid && resp_outcome == label_ctrl_pkg::OUT_DONE_L2);

endmodule
`default_nettype wire

// file: testbench/partition_label_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module partition_label_control_tb;
  // ***********************************************
  // Stimulus and observed signals
  // ***********************************************
  localparam label_ctrl_pkg::outcome_t dl2 = label_ctrl_pkg::OUT_DONE_L2;
  localparam label_ctrl_pkg::outcome_t dl1 = label_ctrl_pkg::OUT_DONE_L1;
  localparam label_ctrl_pkg::outcome_t mem = label_ctrl_pkg::OUT_MEM;
  localparam label_ctrl_pkg::outcome_t tl2 = label_ctrl_pkg::OUT_TRAP_L2;
  localparam label_ctrl_pkg::outcome_t tl3 = label_ctrl_pkg::OUT_TRAP_L3;
  localparam label_ctrl_pkg::outcome_t und = label_ctrl_pkg::OUT_UNDEF;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic acc_valid = 1'h0;
  label_ctrl_pkg::access_t acc = '0;
  label_ctrl_pkg::context_t ctx = '0;
  logic l3_en = 1'h0;
  logic hier_alt = 1'h0;
  logic hi_force = 1'h0;
  logic hyp_trap = 1'h0;
  logic l1_we = 1'h0;
  logic l1_wd = 1'h0;
  logic rv, rv3, en, en3, id_trap, sm_trap, l0_trap, l1_trap;
  label_ctrl_pkg::outcome_t oc, oc3;
  logic [5:0] cls, cls3;
  logic [63:0] rd, rd3;
  logic [11:0] moff;
  label_ctrl_pkg::labels_t lb;
  int miscompares = 0;
  int check_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  // One instance without level three, one with it, on the same stimulus
  partition_label_control u_partition_label_control (
    .ref_clk(ref_clk), .rst(rst), .acc_valid(acc_valid), .acc(acc), .ctx(ctx),
    .l3_label_enable(l3_en), .hierarchical_alt_space_enable(hier_alt),
    .higher_alt_force(hi_force), .hyp_id_access_trap(hyp_trap),
    .l1_enable_we(l1_we), .l1_enable_wdata(l1_wd),
    .resp_valid(rv), .resp_outcome(oc), .resp_class(cls), .resp_rdata(rd),
    .resp_mem_offset(moff), .labels(lb), .label_enable(en),
    .id_access_trap(id_trap), .streaming_label_trap(sm_trap),
    .level0_label_trap(l0_trap), .level1_label_trap(l1_trap));

  partition_label_control #(.HAVE_L3(1'h1)) u_partition_label_control_l3 (
    .ref_clk(ref_clk), .rst(rst), .acc_valid(acc_valid), .acc(acc), .ctx(ctx),
    .l3_label_enable(l3_en), .hierarchical_alt_space_enable(hier_alt),
    .higher_alt_force(hi_force), .hyp_id_access_trap(hyp_trap),
    .l1_enable_we(l1_we), .l1_enable_wdata(l1_wd),
    .resp_valid(rv3), .resp_outcome(oc3), .resp_class(cls3), .resp_rdata(rd3),
    .resp_mem_offset(), .labels(), .label_enable(en3),
    .id_access_trap(), .streaming_label_trap(),
    .level0_label_trap(), .level1_label_trap());

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Request one cycle, answer looked at half a cycle after it is taken
  task automatic access(input logic [1:0] lvl, input logic wr, input logic n1,
                        input logic [63:0] wd);
    @(negedge ref_clk);
    acc_valid = 1'h1;
    acc.level = label_ctrl_pkg::level_t'(lvl);
    acc.is_write = wr;
    acc.names_l1 = n1;
    acc.wdata = wd;
    @(negedge ref_clk);
    // The answer flag must be set in both instances
    check("resp_valid", {62'h0, rv, rv3}, 64'h3);
    acc_valid = 1'h0;
    @(negedge ref_clk);
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  // Outcome and class of both instances, memory offset of the first only, for one access
  task automatic outcome(input logic [1:0] lvl, input logic n1, input logic wr,
                         input logic [7:0] c, input label_ctrl_pkg::outcome_t o,
                         input label_ctrl_pkg::outcome_t o3);
    ctx = label_ctrl_pkg::context_t'(c);
    access(lvl, wr, n1, {64{1'h1}});
    check("outcome", {58'h0, oc, oc3}, {58'h0, o, o3});
    check("class", {52'h0, cls, cls3}, {52'h0, (o == tl2 || o == tl3) ? 6'h18 : 6'h0,
          (o3 == tl2 || o3 == tl3) ? 6'h18 : 6'h0});
    check("mem_offset", {52'h0, moff}, {52'h0, (o == mem) ? 12'h900 : 12'h0});
  endtask

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_reset();
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("rdata", rd, 64'h0003_0000_0000_0000);
    check("rdata_l3", rd3, 64'h0);
    check("enable", {62'h0, en, en3}, 64'h0);
    check("lower_traps", {62'h0, l0_trap, l1_trap}, 64'h3);
    $display("test reset done");
  endtask

  task automatic t_fields();
    access(2'h3, 1'h1, 1'h0, {64{1'h1}});
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("rdata", rd, 64'h85c7_ffff_ffff_ffff);
    check("rdata_l3", rd3, 64'h05c7_ffff_ffff_ffff);
    settle();
    check("enable", {63'h0, en}, 64'h1);
    check("traps", {60'h0, id_trap, sm_trap, l0_trap, l1_trap}, 64'hf);
    l3_en = 1'h1;
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("rdata_l3_en", {63'h0, rd3[63]}, 64'h1);
    check("enable_l3", {63'h0, en3}, 64'h1);
    l3_en = 1'h0;
    settle();
    check("enable_l3_off", {63'h0, en3}, 64'h0);
    $display("test fields done");
  endtask

  task automatic t_labels();
    access(2'h2, 1'h1, 1'h0, 64'h8180_abcd_1234_5678);
    access(2'h2, 1'h0, 1'h0, 64'h0);
    check("rdata", rd, 64'h81c0_abcd_1234_5678);
    settle();
    check("labels", 64'(lb), 64'({1'h1, 16'h1234, 16'h5678, 8'hab, 8'hcd, 2'h0}));
    hier_alt = 1'h1;
    settle();
    check("alt_space", {62'h0, lb.own_alt_space, lb.lower_alt_space}, 64'h3);
    access(2'h2, 1'h1, 1'h0, 64'h0000_abcd_1234_5678);
    settle();
    check("labels_off", {63'(lb), en}, {63'({1'h1, 50'h0}), 1'h0});
    hier_alt = 1'h0;
    $display("test labels done");
  endtask

  task automatic t_force();
    hi_force = 1'h1;
    access(2'h3, 1'h1, 1'h0, 64'h0);
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("forced", rd, 64'h0040_0000_0000_0000);
    hi_force = 1'h0;
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("unforced", rd, 64'h0);
    hyp_trap = 1'h1;
    settle();
    check("id_trap_hyp", {60'h0, id_trap, sm_trap, l0_trap, l1_trap}, 64'h8);
    hyp_trap = 1'h0;
    settle();
    check("id_trap_off", {63'h0, id_trap}, 64'h0);
    $display("test force done");
  endtask

  task automatic t_disabled();
    access(2'h3, 1'h1, 1'h0, {64{1'h1}});
    ctx.el2_enabled = 1'h0;
    settle();
    check("labels_no_l2", 64'(lb), 64'h0);
    check("traps_no_l2", {60'h0, id_trap, sm_trap, l0_trap, l1_trap}, 64'h0);
    ctx.el2_enabled = 1'h1;
    settle();
    check("labels_l2", {63'h0, lb.active}, 64'h1);
    $display("test disabled done");
  endtask

  task automatic t_shared();
    access(2'h3, 1'h1, 1'h0, 64'h0);
    l1_we = 1'h1;
    l1_wd = 1'h1;
    @(negedge ref_clk);
    l1_we = 1'h0;
    settle();
    check("shared_enable", {63'h0, en}, 64'h1);
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("shared_read", rd, 64'h8000_0000_0000_0000);
    access(2'h3, 1'h1, 1'h0, 64'h0);
    $display("test shared done");
  endtask

  task automatic t_outcomes();
    outcome(2'h0, 1'h0, 1'h0, 8'h80, und, und);
    outcome(2'h1, 1'h0, 1'h0, 8'h80, und, und);
    outcome(2'h1, 1'h0, 1'h0, 8'hc0, tl2, tl2);
    outcome(2'h1, 1'h0, 1'h0, 8'hc1, tl2, tl3);
    outcome(2'h1, 1'h0, 1'h0, 8'h40, und, und);
    outcome(2'h2, 1'h0, 1'h0, 8'h81, dl2, tl3);
    outcome(2'h3, 1'h0, 1'h0, 8'h81, dl2, dl2);
    outcome(2'h2, 1'h0, 1'h0, 8'h87, dl2, und);
    outcome(2'h1, 1'h0, 1'h0, 8'hc7, tl2, und);
    outcome(2'h2, 1'h1, 1'h0, 8'h88, dl2, dl2);
    outcome(2'h2, 1'h1, 1'h0, 8'h80, dl1, dl1);
    outcome(2'h1, 1'h1, 1'h0, 8'hf0, mem, mem);
    outcome(2'h1, 1'h1, 1'h0, 8'hd0, dl1, dl1);
    outcome(2'h3, 1'h1, 1'h0, 8'h80, dl1, dl1);
    ctx = label_ctrl_pkg::context_t'(8'h80);
    access(2'h3, 1'h1, 1'h0, 64'h0001_0000_0000_0000);
    outcome(2'h1, 1'h1, 1'h0, 8'hf0, tl2, tl2);
    outcome(2'h1, 1'h1, 1'h0, 8'h70, dl1, dl1);
    outcome(2'h1, 1'h1, 1'h0, 8'hf1, tl2, tl3);
    outcome(2'h0, 1'h0, 1'h1, 8'h80, und, und);
    outcome(2'h2, 1'h0, 1'h1, 8'h87, dl2, und);
    access(2'h3, 1'h0, 1'h0, 64'h0);
    check("unchanged_l3", rd3, 64'h0001_0000_0000_0000);
    check("written", rd, 64'h85c7_ffff_ffff_ffff);
    $display("test outcomes done");
  endtask

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    ctx.el2_enabled = 1'h1;
    repeat (20) @(negedge ref_clk);
    rst = 1'h0;
    t_reset();
    t_fields();
    t_labels();
    t_force();
    t_disabled();
    t_shared();
    t_outcomes();
    finish_test();
  end

  // A hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
